// ---- bench/ssr_bank_checker.sv ----
// Assertions on the outputs of the serial register bank.
// Assumes one system clock domain and the active-low reset.
`timescale 1ns/1ps

module ssr_bank_checker
  import ssr_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire logic               int_fraction_numerator_loaded,
  input wire logic               ramp_enable,
  input wire logic [MUX_W-1:0]   output_mux_select,
  input wire logic [INT_W-1:0]   integer_value,
  input wire logic [FRACTION_NUMERATOR_W-1:0]  fraction_numerator,
  input wire logic               phase_adjust_enable,
  input wire logic [PHASE_W-1:0] phase_word,
  input wire logic [PHASE_W-1:0] phase_offset,
  input wire logic               phase_advance
);
  // ****
  // Timing relations
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Register 0 load and the buffered phase step land on the same edge
  sequence adv_s;
    int_fraction_numerator_loaded && phase_advance;
  endsequence

  load_pulse_a: assert property (int_fraction_numerator_loaded |=> !int_fraction_numerator_loaded)
    else $error("load pulse longer than one cycle");
  ramp_hold_a: assert property ($changed(ramp_enable) |-> int_fraction_numerator_loaded)
    else $error("ramp enable moved without a register 0 load");
  mux_hold_a: assert property ($changed(output_mux_select) |-> int_fraction_numerator_loaded)
    else $error("mux select moved without a register 0 load");
  int_hold_a: assert property ($changed(integer_value) |-> int_fraction_numerator_loaded)
    else $error("integer value moved without a register 0 load");
  fraction_numerator_high_a: assert property ($changed(fraction_numerator[24:13]) |-> int_fraction_numerator_loaded)
    else $error("upper fraction moved without a register 0 load");
  fraction_numerator_low_a: assert property ($changed(fraction_numerator[12:0]) |-> int_fraction_numerator_loaded)
    else $error("lower fraction moved outside the buffered update");
  phase_buf_a: assert property ($changed(phase_word) |-> int_fraction_numerator_loaded)
    else $error("phase word moved outside the buffered update");
  adv_cause_a: assert property (phase_advance |-> int_fraction_numerator_loaded && phase_adjust_enable)
    else $error("phase step without enable or load");
  phase_sum_a: assert property (adv_s |-> phase_offset == 12'($past(phase_offset) + phase_word))
    else $error("phase offset did not advance by the phase word");
  offset_hold_a: assert property (!phase_advance |-> $stable(phase_offset))
    else $error("phase offset moved without a step");
endmodule

bind ssr_serial_bank ssr_bank_checker u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .int_fraction_numerator_loaded(int_fraction_numerator_loaded),
  .ramp_enable(ramp_enable), .output_mux_select(output_mux_select),
  .integer_value(integer_value), .fraction_numerator(fraction_numerator),
  .phase_adjust_enable(phase_adjust_enable), .phase_word(phase_word),
  .phase_offset(phase_offset), .phase_advance(phase_advance)
);

// ---- bench/ssr_host_model.sv ----
// Host side of the three-wire configuration port.
// Serial clock period 48 ns; it stands still low between frames.
`timescale 1ns/1ps

module ssr_host_model (
  output logic serial_clk,
  output logic serial_data,
  output logic latch_strobe
);
  // ****
  // Idle levels
  // ****
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    latch_strobe = 1'b0;
  end

  // Shift one word, then strobe it; odd offsets keep phase unrelated
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      serial_data = w[i];
      #13 serial_clk = 1'b1;
      #24 serial_clk = 1'b0;
      #11;
    end
    serial_data = ~w[0]; // No stale bit once the frame is over
    #16 latch_strobe = 1'b1;
    #40 latch_strobe = 1'b0;
    #56;
  endtask
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the serial register bank.
// Assumes the host model drives the port; results read at the outputs.
`timescale 1ns/1ps

module tb_top
  import ssr_pkg::*;
;
  logic                clk_sys;
  logic                rstn;
  wire logic           serial_clk, serial_data, latch_strobe;
  wire logic           ramp_enable, phase_adjust_enable, phase_advance, int_fraction_numerator_loaded;
  wire logic [3:0]     output_mux_select, charge_pump_current;
  wire logic [11:0]    integer_value, phase_word, phase_offset;
  wire logic [24:0]    fraction_numerator;
  wire logic [1:0]     ramp_mode;
  wire logic [19:0]    step_word;
  wire logic [31:0]    cfg [2:7];
  logic      [31:0]    exp_w [2:7];
  int                  error_cnt, num_checks, n_load, n_adv;

  ssr_host_model u_host (.serial_clk(serial_clk), .serial_data(serial_data),
    .latch_strobe(latch_strobe));

  ssr_serial_bank DUT (.clk_sys(clk_sys), .rstn(rstn), .serial_clk(serial_clk),
    .serial_data(serial_data), .latch_strobe(latch_strobe), .ramp_enable(ramp_enable),
    .output_mux_select(output_mux_select), .integer_value(integer_value),
    .fraction_numerator(fraction_numerator), .phase_adjust_enable(phase_adjust_enable),
    .phase_word(phase_word), .phase_offset(phase_offset), .phase_advance(phase_advance),
    .int_fraction_numerator_loaded(int_fraction_numerator_loaded), .r_divider_config(cfg[2]), .function_config(cfg[3]),
    .clock_divider_config(cfg[4]), .deviation_config(cfg[5]), .sweep_step_config(cfg[6]),
    .delay_config(cfg[7]), .charge_pump_current(charge_pump_current), .r_counter(),
    .clk1_divider(), .ramp_mode(ramp_mode), .power_down(), .clk2_divider(),
    .deviation_word(), .deviation_offset(), .step_word(step_word), .delay_start_word());

  // ****
  // Clock, pulse counters, helpers
  // ****
  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  // Count one-cycle pulses so a stuck or doubled pulse shows up
  always @(posedge clk_sys) begin
    if (int_fraction_numerator_loaded === 1'b1) n_load++;
    if (phase_advance === 1'b1) n_adv++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Strobe changes land on falling edges; results settled two cycles later
  task automatic wr(input logic [31:0] w);
    @(negedge clk_sys);
    u_host.send(w);
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end

  // ****
  // Main sequence
  // ****
  initial begin
    rstn = 1'b0;
    repeat (10) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (3) @(negedge clk_sys);
    wr({3'h0, 1'b1, 13'h1555, 12'h200, 3'h1}); // Reserved bits zero
    chk("fraction_numerator_early", fraction_numerator, 0);
    chk("phase_early", phase_word, 0);
    wr({1'b1, 4'ha, 12'h123, 12'habc, 3'h0});
    chk("ramp_on", ramp_enable, 1);
    chk("mux", output_mux_select, 4'ha);
    chk("int", integer_value, 12'h123);
    chk("fraction_numerator", fraction_numerator, {12'habc, 13'h1555});
    chk("ph_en", phase_adjust_enable, 1);
    chk("ph_word", phase_word, 12'h200);
    chk("ph_off", phase_offset, 12'h200);
    wr({1'b0, 4'h3, 12'h045, 12'h001, 3'h0});
    chk("ramp_off", ramp_enable, 0);
    chk("ph_spent", phase_offset, 12'h200);
    chk("frac2", fraction_numerator, {12'h001, 13'h1555});
    // Every remaining code once
    for (int c = 2; c < 8; c++) begin
      exp_w[c] = {29'h0b4792de + 29'(c), 3'(c)};
      wr(exp_w[c]);
    end
    for (int c = 3; c < 8; c++) begin
      chk("cfg", cfg[c], exp_w[c]);
    end
    chk("rdiv_held", cfg[2], 0);
    wr({3'h0, 1'b0, 13'h00aa, 12'h000, 3'h1}); // Phase word zero when unused
    wr({1'b1, 4'h5, 12'h7ff, 12'hfff, 3'h0});
    chk("rdiv", cfg[2], exp_w[2]);
    chk("cp", charge_pump_current, exp_w[2][27:24]);
    chk("rmode", ramp_mode, exp_w[3][11:10]);
    chk("step", step_word, exp_w[6][22:3]);
    chk("ph_off_en", phase_adjust_enable, 0);
    chk("ph_idle", phase_offset, 12'h200);
    chk("frac3", fraction_numerator, {12'hfff, 13'h00aa});
    // Phase sum wraps modulo 4096
    wr({3'h0, 1'b1, 13'h0001, 12'hfff, 3'h1});
    wr({1'b0, 4'h0, 12'h010, 12'h000, 3'h0});
    chk("ph_wrap", phase_offset, 12'h1ff);
    chk("loads", n_load, 4);
    chk("steps", n_adv, 2);
    give_verdict();
  end
endmodule

// ---- hw/ssr_serial_bank.sv ----
// Write-only configuration register bank behind a three-wire port.
// Assumes the host holds the serial clock still while the latch strobe
// is high, and holds the strobe high for at least three system clocks.
//
// Functional notes
// RL1: Code 000 stores the word as the integer and fraction-high register.
// RL2: Code 001 stores the word as the fraction-low and phase register.
// RL3: Bit 31 of register 0 enables the frequency ramp.
// RL4: Bits 30..27 of register 0 select the output multiplexer.
// RL5: Bits 26..15 of register 0 give the 12-bit integer divider.
// RL6: Numerator is register 0 bits 14..3 above register 1 bits 27..15.
// RL7: Host writes zeros into reserved bits of register 1.
// RL8: Bit 28 of register 1 enables phase adjustment.
// RL9: Phase advances by the 12-bit word, 360/4096 degrees per count.
// RL10: A new phase word acts only after the next register 0 write.
// RL11: Host zeroes the phase word when unused, sets enable when used.
// RL12: Words shift in MSB first, one bit per rising serial edge.
// RL13: Strobe rising edge copies the word to one of eight registers.
// RL14: Double-buffered fields act after the next register 0 write.
// RL15: Codes 011 to 111 store function, clock, deviation, step, delay.
`timescale 1ns/1ps

module ssr_serial_bank
  import ssr_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  input  wire logic               serial_clk,
  input  wire logic               serial_data,
  input  wire logic               latch_strobe,
  output logic                    ramp_enable,
  output logic [MUX_W-1:0]        output_mux_select,
  output logic [INT_W-1:0]        integer_value,
  output logic [FRACTION_NUMERATOR_W-1:0]       fraction_numerator,
  output logic                    phase_adjust_enable,
  output logic [PHASE_W-1:0]      phase_word,
  output logic [PHASE_W-1:0]      phase_offset,
  output logic                    phase_advance,
  output logic                    int_fraction_numerator_loaded,
  output logic [WORD_W-1:0]       r_divider_config,
  output logic [WORD_W-1:0]       function_config,
  output logic [WORD_W-1:0]       clock_divider_config,
  output logic [WORD_W-1:0]       deviation_config,
  output logic [WORD_W-1:0]       sweep_step_config,
  output logic [WORD_W-1:0]       delay_config,
  output logic [CP_MSB-CP_LSB:0]  charge_pump_current,
  output logic [RCNT_MSB-RCNT_LSB:0] r_counter,
  output logic [CLK1_MSB-CLK1_LSB:0] clk1_divider,
  output logic [RMODE_MSB-RMODE_LSB:0] ramp_mode,
  output logic                    power_down,
  output logic [CLK2_MSB-CLK2_LSB:0] clk2_divider,
  output logic [DEV_MSB-DEV_LSB:0]   deviation_word,
  output logic [DOFS_MSB-DOFS_LSB:0] deviation_offset,
  output logic [STEP_MSB-STEP_LSB:0] step_word,
  output logic [DLY_MSB-DLY_LSB:0]   delay_start_word
);

  // ****************************************
  // Serial clock domain
  // ****************************************
  logic [WORD_W-1:0] shift_word;

  // Only the shift register lives on the serial clock
  ssr_shift_port #(
    .W (WORD_W)
  ) u_shift (
    .serial_clk  (serial_clk),
    .rstn        (rstn),
    .serial_data (serial_data),
    .shift_word  (shift_word)
  );

  // ****************************************
  // Strobe crossing
  // ****************************************
  logic [SYNC_W-1:0] strobe_sync;
  logic              strobe_seen;
  logic              load_pulse;

  // Two flops, then one more for the edge; only the last stage is read
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      strobe_sync <= '0;
      strobe_seen <= 1'b0;
    end else begin
      strobe_sync <= {strobe_sync[SYNC_W-2:0], latch_strobe};
      strobe_seen <= strobe_sync[SYNC_W-1];
    end
  end

  // Rising edge of the synchronised strobe [RL13]
  assign load_pulse = strobe_sync[SYNC_W-1] & ~strobe_seen;

  // ****************************************
  // Word capture
  // ****************************************
  // The shift word is quiet while the strobe is high, since the host
  // has stopped the serial clock, so a sampled copy is safe to use.
  logic [WORD_W-1:0] held_word;
  logic              held_valid;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      held_word  <= WORD_RESET;
      held_valid <= 1'b0;
    end else begin
      held_valid <= load_pulse;
      if (load_pulse) begin
        held_word <= shift_word;
      end
    end
  end

  // ****************************************
  // Select decode
  // ****************************************
  logic [CODE_W-1:0] held_code;
  logic              load_r0;
  logic              load_r1;

  // Select code in the three LSBs [RL13]
  assign held_code = held_word[CODE_W-1:0];
  assign load_r0   = held_valid && (held_code == SEL_INT_FRACTION_NUMERATOR_HI);   // [RL1]
  assign load_r1   = held_valid && (held_code == SEL_FRACTION_NUMERATOR_LO_PHASE); // [RL2]

  // ****************************************
  // Staging registers
  // ****************************************
  logic [WORD_W-1:0] stage_reg [NUM_REGS];

  // One staging register per select code, written only on its own code
  generate
    for (genvar gi = 0; gi < NUM_REGS; gi++) begin : g_stage
      logic hit;
      assign hit = held_valid && (held_code == CODE_W'(gi)); // [RL13] [RL15]
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          stage_reg[gi] <= WORD_RESET;
        end else if (hit) begin
          stage_reg[gi] <= held_word;
        end
      end
    end
  endgenerate

  // ****************************************
  // Double-buffered copies
  // ****************************************
  // Register 1 and register 2 contents act only when register 0 is
  // written, so a frequency change needs register 1 first. [RL14]
  logic [WORD_W-1:0] active_r1;
  logic [WORD_W-1:0] active_r2;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      active_r1 <= WORD_RESET;
      active_r2 <= WORD_RESET;
    end else if (load_r0) begin
      active_r1 <= stage_reg[SEL_FRACTION_NUMERATOR_LO_PHASE]; // [RL14]
      active_r2 <= stage_reg[SEL_R_DIVIDER];     // [RL14]
    end
  end

  // ****************************************
  // Phase adjustment
  // ****************************************
  // A phase word is used once: it is armed by a register 1 write and
  // spent by the next register 0 write. Both cannot load in one cycle.
  logic              phase_armed;
  logic              phase_fire;
  logic [PHASE_W-1:0] staged_phase;
  logic [PHASE_W-1:0] next_phase_offset;

  assign staged_phase = stage_reg[SEL_FRACTION_NUMERATOR_LO_PHASE][PH_MSB:PH_LSB];
  assign phase_fire   = load_r0 && phase_armed &&
                        stage_reg[SEL_FRACTION_NUMERATOR_LO_PHASE][PH_EN_BIT]; // [RL8] [RL10]
  // Wraps at 4096 counts, one count is 360/4096 degrees [RL9]
  assign next_phase_offset = phase_offset + staged_phase;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      phase_armed <= 1'b0;
    end else if (load_r1) begin
      phase_armed <= 1'b1;
    end else if (load_r0) begin
      phase_armed <= 1'b0; // [RL10]
    end
  end

  // Phase step pulse and running offset, one cycle after the load
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      phase_offset  <= '0;
      phase_advance <= 1'b0;
    end else begin
      phase_advance <= phase_fire;
      if (phase_fire) begin
        phase_offset <= next_phase_offset; // [RL9]
      end
    end
  end

  // ****************************************
  // Register 0 load marker
  // ****************************************
  // Downstream modulator and lock detect restart on this pulse
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      int_fraction_numerator_loaded <= 1'b0;
    end else begin
      int_fraction_numerator_loaded <= load_r0;
    end
  end

  // ****************************************
  // Register 0 fields
  // ****************************************
  // Register 0 itself is not buffered; it acts on its own write
  assign ramp_enable       = stage_reg[SEL_INT_FRACTION_NUMERATOR_HI][RAMP_ON_BIT];      // [RL3]
  assign output_mux_select = stage_reg[SEL_INT_FRACTION_NUMERATOR_HI][MUX_MSB:MUX_LSB];  // [RL4]
  assign integer_value     = stage_reg[SEL_INT_FRACTION_NUMERATOR_HI][INT_MSB:INT_LSB];  // [RL5]

  // High 12 bits direct, low 13 bits from the buffered copy [RL6]
  assign fraction_numerator = {stage_reg[SEL_INT_FRACTION_NUMERATOR_HI][FHI_MSB:FHI_LSB],
                               active_r1[FLO_MSB:FLO_LSB]};

  // ****************************************
  // Register 1 fields
  // ****************************************
  // Reserved bits are kept as written; the host keeps them zero
  assign phase_adjust_enable = active_r1[PH_EN_BIT];        // [RL8]
  assign phase_word          = active_r1[PH_MSB:PH_LSB];    // [RL9]

  // ****************************************
  // Register 2 fields
  // ****************************************
  assign r_divider_config    = active_r2;
  assign charge_pump_current = active_r2[CP_MSB:CP_LSB];
  assign r_counter           = active_r2[RCNT_MSB:RCNT_LSB];
  assign clk1_divider        = active_r2[CLK1_MSB:CLK1_LSB];

  // ****************************************
  // Registers 3 to 7
  // ****************************************
  // Stored whole and acted on at once; fields at their fixed positions
  assign function_config      = stage_reg[SEL_FUNCTION];   // [RL15]
  assign clock_divider_config = stage_reg[SEL_CLOCK];      // [RL15]
  assign deviation_config     = stage_reg[SEL_DEVIATION];  // [RL15]
  assign sweep_step_config    = stage_reg[SEL_STEP];       // [RL15]
  assign delay_config         = stage_reg[SEL_DELAY];      // [RL15]

  assign ramp_mode        = function_config[RMODE_MSB:RMODE_LSB];
  assign power_down       = function_config[PDOWN_BIT];
  assign clk2_divider     = clock_divider_config[CLK2_MSB:CLK2_LSB];
  assign deviation_word   = deviation_config[DEV_MSB:DEV_LSB];
  assign deviation_offset = deviation_config[DOFS_MSB:DOFS_LSB];
  assign step_word        = sweep_step_config[STEP_MSB:STEP_LSB];
  assign delay_start_word = delay_config[DLY_MSB:DLY_LSB];

endmodule

// ---- hw/ssr_shift_port.sv ----
// Serial input shift register of the configuration port.
// Runs on the serial clock; the host stops that clock outside frames.
`timescale 1ns/1ps

module ssr_shift_port
  import ssr_pkg::*;
#(
  parameter int W = WORD_W
) (
  input  wire logic         serial_clk,
  input  wire logic         rstn,
  input  wire logic         serial_data,
  output logic [W-1:0]      shift_word
);

  // ****************************************
  // Shift, first bit ends at the top
  // ****************************************
  // One bit per rising serial edge, MSB first [RL12]
  always_ff @(posedge serial_clk or negedge rstn) begin
    if (!rstn) begin
      shift_word <= WORD_RESET;
    end else begin
      shift_word <= {shift_word[W-2:0], serial_data};
    end
  end

endmodule

// ---- shared/ssr_pkg.sv ----
// Constants for the serial configuration register bank.
// Assumes one 32-bit word per load, select code in the low three bits.
package ssr_pkg;

  // ****************************************
  // Word and select code
  // ****************************************
  localparam int WORD_W   = 32;
  localparam int CODE_W   = 3;
  localparam int NUM_REGS = 8;
  localparam int SYNC_W   = 2;

  localparam logic [CODE_W-1:0] SEL_INT_FRACTION_NUMERATOR_HI   = 3'h0;
  localparam logic [CODE_W-1:0] SEL_FRACTION_NUMERATOR_LO_PHASE = 3'h1;
  localparam logic [CODE_W-1:0] SEL_R_DIVIDER     = 3'h2;
  localparam logic [CODE_W-1:0] SEL_FUNCTION      = 3'h3;
  localparam logic [CODE_W-1:0] SEL_CLOCK         = 3'h4;
  localparam logic [CODE_W-1:0] SEL_DEVIATION     = 3'h5;
  localparam logic [CODE_W-1:0] SEL_STEP          = 3'h6;
  localparam logic [CODE_W-1:0] SEL_DELAY         = 3'h7;

  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;

  // ****************************************
  // Integer and fraction-high word
  // ****************************************
  localparam int RAMP_ON_BIT = 31;
  localparam int MUX_MSB     = 30;
  localparam int MUX_LSB     = 27;
  localparam int INT_MSB     = 26;
  localparam int INT_LSB     = 15;
  localparam int FHI_MSB     = 14;
  localparam int FHI_LSB     = 3;
  localparam int MUX_W       = 4;
  localparam int INT_W       = 12;
  localparam int FRACTION_NUMERATOR_W      = 25;

  // ****************************************
  // Fraction-low and phase word
  // ****************************************
  localparam int PH_EN_BIT = 28;
  localparam int FLO_MSB   = 27;
  localparam int FLO_LSB   = 15;
  localparam int PH_MSB    = 14;
  localparam int PH_LSB    = 3;
  localparam int PHASE_W   = 12;

  // ****************************************
  // Other configuration words
  // ****************************************
  localparam int CP_MSB    = 27;
  localparam int CP_LSB    = 24;
  localparam int RCNT_MSB  = 19;
  localparam int RCNT_LSB  = 15;
  localparam int CLK1_MSB  = 14;
  localparam int CLK1_LSB  = 3;
  localparam int RMODE_MSB = 11;
  localparam int RMODE_LSB = 10;
  localparam int PDOWN_BIT = 5;
  localparam int CLK2_MSB  = 18;
  localparam int CLK2_LSB  = 7;
  localparam int DEV_MSB   = 18;
  localparam int DEV_LSB   = 3;
  localparam int DOFS_MSB  = 22;
  localparam int DOFS_LSB  = 19;
  localparam int STEP_MSB  = 22;
  localparam int STEP_LSB  = 3;
  localparam int DLY_MSB   = 14;
  localparam int DLY_LSB   = 3;

endpackage
